// ===== logic/flash_cmd_cfg.svh
// Constants of the serial flash instruction decoder: opcodes,
// clock ceilings, lane counts and link timing.
// Assumes inclusion by bare name from the design files; the package does not include it.
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

// ----------------------------------------
// Instruction bytes
// ----------------------------------------
`define OPC_STAT_CFG_WR   8'h01
`define OPC_PAGE_PROG     8'h02
`define OPC_READ          8'h03
`define OPC_LATCH_CLR     8'h04
`define OPC_LATCH_SET     8'h06
`define OPC_QUICK         8'h0b
`define OPC_QUICK_W       8'h0c
`define OPC_DR_QUICK      8'h0d
`define OPC_DR_QUICK_W    8'h0e
`define OPC_PAGE_PROG_W   8'h12
`define OPC_READ_W        8'h13
`define OPC_BANK_FETCH    8'h16
`define OPC_BANK_STORE    8'h17
`define OPC_FLAG_CLR      8'h30
`define OPC_QPROG_A       8'h32
`define OPC_QPROG_W       8'h34
`define OPC_QPROG_B       8'h38
`define OPC_TWO_OUT       8'h3b
`define OPC_TWO_OUT_W     8'h3c
`define OPC_LP_FETCH      8'h41
`define OPC_LP_NV_STORE   8'h43
`define OPC_LP_VOL_STORE  8'h4a
`define OPC_PARAM_READ    8'h5a
`define OPC_WIPE_ALL_A    8'h60
`define OPC_FOUR_OUT      8'h6b
`define OPC_FOUR_OUT_W    8'h6c
`define OPC_SIGNATURE     8'h90
`define OPC_IDENTITY      8'h9f
`define OPC_PERF_MODE     8'ha3
`define OPC_BANK_LEGACY   8'hb9
`define OPC_TWO_IO        8'hbb
`define OPC_TWO_IO_W      8'hbc
`define OPC_DR_TWO_IO     8'hbd
`define OPC_DR_TWO_IO_W   8'hbe
`define OPC_WIPE_ALL_B    8'hc7
`define OPC_SECTOR        8'hd8
`define OPC_SECTOR_W      8'hdc
`define OPC_RSVD_A        8'he5
`define OPC_RSVD_B        8'he6
`define OPC_FOUR_IO       8'heb
`define OPC_FOUR_IO_W     8'hec
`define OPC_DR_FOUR_IO    8'hed
`define OPC_DR_FOUR_IO_W  8'hee
`define OPC_MODE_EXIT     8'hff

// ----------------------------------------
// Clock ceilings in MHz, lane counts
// ----------------------------------------
`define FMAX_NONE  8'h00
`define FMAX_SLOW  8'h32
`define FMAX_DDR   8'h50
`define FMAX_MULTI 8'h68
`define FMAX_STD   8'h85
`define LANES_X1   3'h1
`define LANES_X2   3'h2
`define LANES_X4   3'h4

// ----------------------------------------
// Link timing and counters
// ----------------------------------------
`define CLK_MHZ    50
`define SCK_HALF   8'h04
`define BYTE_BITS  4'h8
`define PE_CNT_W   32

`endif

// ===== logic/flash_cmd_pkg.sv
// Types shared by both link ends and the opcode classifier.
// Assumes flash_cmd_cfg.svh is on the include path.
`default_nettype none
package flash_cmd_pkg;
	// Operation classes; wide forms share a class, addr tells them apart
	typedef enum logic [4:0] {
		normal_read, quick_read, double_rate_quick_read,
		two_lane_out_read, four_lane_out_read, two_lane_io_read,
		double_rate_two_lane_read, four_lane_io_read,
		double_rate_four_lane_read, page_prog, four_lane_page_prog,
		sector_wipe, whole_array_wipe, status_config_write,
		write_latch_set, write_latch_clear, status_flag_clear,
		bank_reg_fetch, bank_reg_store, bank_reg_legacy_access,
		learning_pattern_fetch, learning_pattern_nv_store,
		learning_pattern_volatile_store, discoverable_param_read,
		identity_read, maker_signature_read, multi_lane_perf_mode,
		continuous_mode_exit, op_reserved, cont_read_addr, op_unknown
	} op_t;

	// Address phase width
	typedef enum logic [1:0] {addr_none, addr_3or4, addr_4only} addr_mode_t;

	// Decoded description of one instruction byte
	typedef struct packed {
		op_t        op;
		addr_mode_t addr;
		logic [2:0] lanes;
		logic       ddr;
		logic [7:0] fmax;
		logic       known;
		logic       nv_wr;
	} cmd_info_t;

	// Host sequencer states
	typedef enum {h_idle, h_lead, h_high, h_low, h_trail} host_state_t;
endpackage
`default_nettype wire

// ===== logic/flash_link_if.sv
// Serial link between host controller and flash decoder.
// Assumes the host makes the serial clock; no two-way lanes are carried.
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic si;

	// Host drives all three lines
	modport host_mp (output sck, output cs_n, output si);
	// Device only listens
	modport dev_mp (input sck, input cs_n, input si);
endinterface
`default_nettype wire

// ===== logic/opcode_classifier.sv
// Pure decode of one instruction byte into its operation class.
// Assumes a stable byte; cont selects continuous read interpretation.
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_cfg.svh"
module opcode_classifier import flash_cmd_pkg::*; (
	input  wire logic [7:0] code,
	input  wire logic       cont,
	output var  cmd_info_t  info
);
	// Builds one description
	function automatic cmd_info_t mk(op_t o, addr_mode_t a, logic [2:0] l,
		logic d, logic [7:0] f, logic k);
		cmd_info_t r;
		r = '{op: o, addr: a, lanes: l, ddr: d, fmax: f, known: k, nv_wr: 1'b0};
		return r;
	endfunction

	// ----------------------------------------
	// Opcode table
	// ----------------------------------------
	always_comb begin
		info = mk(op_unknown, addr_none, `LANES_X1, 1'b0, `FMAX_NONE, 1'b0);
		if (cont) begin
			if (code == `OPC_MODE_EXIT)
				info = mk(continuous_mode_exit, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
			else
				info = mk(cont_read_addr, addr_none, `LANES_X1, 1'b0, `FMAX_NONE, 1'b1);
		end else begin
			case (code)
				`OPC_READ:         info = mk(normal_read, addr_3or4, `LANES_X1, 1'b0, `FMAX_SLOW, 1'b1);
				`OPC_READ_W:       info = mk(normal_read, addr_4only, `LANES_X1, 1'b0, `FMAX_SLOW, 1'b1);
				`OPC_QUICK:        info = mk(quick_read, addr_3or4, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_QUICK_W:      info = mk(quick_read, addr_4only, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_DR_QUICK:     info = mk(double_rate_quick_read, addr_3or4, `LANES_X1, 1'b1, `FMAX_DDR, 1'b1);
				`OPC_DR_QUICK_W:   info = mk(double_rate_quick_read, addr_4only, `LANES_X1, 1'b1, `FMAX_DDR, 1'b1);
				`OPC_TWO_OUT:      info = mk(two_lane_out_read, addr_3or4, `LANES_X2, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_TWO_OUT_W:    info = mk(two_lane_out_read, addr_4only, `LANES_X2, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_FOUR_OUT:     info = mk(four_lane_out_read, addr_3or4, `LANES_X4, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_FOUR_OUT_W:   info = mk(four_lane_out_read, addr_4only, `LANES_X4, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_TWO_IO:       info = mk(two_lane_io_read, addr_3or4, `LANES_X2, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_TWO_IO_W:     info = mk(two_lane_io_read, addr_4only, `LANES_X2, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_DR_TWO_IO:    info = mk(double_rate_two_lane_read, addr_3or4, `LANES_X2, 1'b1, `FMAX_DDR, 1'b1);
				`OPC_DR_TWO_IO_W:  info = mk(double_rate_two_lane_read, addr_4only, `LANES_X2, 1'b1, `FMAX_DDR, 1'b1);
				`OPC_FOUR_IO:      info = mk(four_lane_io_read, addr_3or4, `LANES_X4, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_FOUR_IO_W:    info = mk(four_lane_io_read, addr_4only, `LANES_X4, 1'b0, `FMAX_MULTI, 1'b1);
				`OPC_DR_FOUR_IO:   info = mk(double_rate_four_lane_read, addr_3or4, `LANES_X4, 1'b1, `FMAX_DDR, 1'b1);
				`OPC_DR_FOUR_IO_W: info = mk(double_rate_four_lane_read, addr_4only, `LANES_X4, 1'b1, `FMAX_DDR, 1'b1);
				`OPC_PAGE_PROG:    info = mk(page_prog, addr_3or4, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_PAGE_PROG_W:  info = mk(page_prog, addr_4only, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_QPROG_A, `OPC_QPROG_B:
					info = mk(four_lane_page_prog, addr_3or4, `LANES_X4, 1'b0, `FMAX_DDR, 1'b1);
				`OPC_QPROG_W:      info = mk(four_lane_page_prog, addr_4only, `LANES_X4, 1'b0, `FMAX_DDR, 1'b1);
				`OPC_SECTOR:       info = mk(sector_wipe, addr_3or4, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_SECTOR_W:     info = mk(sector_wipe, addr_4only, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_WIPE_ALL_A, `OPC_WIPE_ALL_B:
					info = mk(whole_array_wipe, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_STAT_CFG_WR: begin
					info = mk(status_config_write, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
					info.nv_wr = 1'b1;
				end
				`OPC_LATCH_SET:    info = mk(write_latch_set, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_LATCH_CLR:    info = mk(write_latch_clear, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_FLAG_CLR:     info = mk(status_flag_clear, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_BANK_FETCH:   info = mk(bank_reg_fetch, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_BANK_STORE:   info = mk(bank_reg_store, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_BANK_LEGACY:  info = mk(bank_reg_legacy_access, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_LP_FETCH:     info = mk(learning_pattern_fetch, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_LP_NV_STORE: begin
					info = mk(learning_pattern_nv_store, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
					info.nv_wr = 1'b1;
				end
				`OPC_LP_VOL_STORE: info = mk(learning_pattern_volatile_store, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_RSVD_A, `OPC_RSVD_B:
					info = mk(op_reserved, addr_none, `LANES_X1, 1'b0, `FMAX_NONE, 1'b0);
				`OPC_PERF_MODE:    info = mk(multi_lane_perf_mode, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b0);
				`OPC_PARAM_READ:   info = mk(discoverable_param_read, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_IDENTITY:     info = mk(identity_read, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_SIGNATURE:    info = mk(maker_signature_read, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				`OPC_MODE_EXIT:    info = mk(continuous_mode_exit, addr_none, `LANES_X1, 1'b0, `FMAX_STD, 1'b1);
				default:           info = mk(op_unknown, addr_none, `LANES_X1, 1'b0, `FMAX_NONE, 1'b0);
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== logic/flash_host_end.sv
// Host controller end: shifts one instruction byte per frame.
// Assumes clk at 50 MHz; it makes the serial clock by division.
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_host_end import flash_cmd_pkg::*; #(
	parameter logic [7:0] SCK_DIV = `SCK_HALF
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	flash_link_if.host_mp   link,
	input  wire logic       start,
	input  wire logic [7:0] opcode,
	output logic            busy,
	output logic            done,
	output logic            refused
);
	// Serial rate in MHz made by the divider
	localparam logic [7:0] LINK_MHZ = 8'(`CLK_MHZ / (2 * SCK_DIV));

	host_state_t st_q;
	logic [7:0]  div_q;
	logic [7:0]  sh_q;
	logic [2:0]  bits_q;
	logic        sck_q, cs_n_q, si_q, busy_q, done_q, ref_q;
	cmd_info_t   info;
	wire         tick = (div_q == SCK_DIV - 8'h01);

	// ----------------------------------------
	// Clock ceiling check
	// ----------------------------------------
	opcode_classifier u_cls (.code(opcode), .cont(1'b0), .info(info));
	wire too_fast = info.known && (info.fmax < LINK_MHZ);

	// Half period divider, runs only inside a frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			div_q <= 8'h00;
		else if (st_q == h_idle || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// ----------------------------------------
	// Frame sequencer, mode 0, MSB first
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= h_idle; sck_q <= 1'b0; cs_n_q <= 1'b1; si_q <= 1'b0;
			sh_q <= 8'h00; bits_q <= 3'h0; busy_q <= 1'b0; done_q <= 1'b0; ref_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			ref_q  <= 1'b0;
			case (st_q)
				h_idle: if (start) begin
					if (too_fast)
						ref_q <= 1'b1;
					else begin
						// open the frame: chip select low, MSB of the opcode onto si
						st_q <= h_lead; cs_n_q <= 1'b0; busy_q <= 1'b1;
						sh_q <= opcode; si_q <= opcode[7]; bits_q <= 3'h0;
					end
				end
				h_lead: if (tick) begin
					st_q <= h_high; sck_q <= 1'b1;
				end
				h_high: if (tick) begin
					sck_q <= 1'b0; bits_q <= bits_q + 3'h1;
					sh_q <= {sh_q[6:0], 1'b0}; si_q <= sh_q[6];
					st_q <= (bits_q == 3'h7) ? h_trail : h_low;
				end
				h_low: if (tick) begin
					st_q <= h_high; sck_q <= 1'b1;
				end
				h_trail: if (tick) begin
					st_q <= h_idle; cs_n_q <= 1'b1; busy_q <= 1'b0; done_q <= 1'b1;
				end
				default: st_q <= h_idle;
			endcase
		end
	end

	// Outputs straight from flops
	assign link.sck  = sck_q;
	assign link.cs_n = cs_n_q;
	assign link.si   = si_q;
	assign busy      = busy_q;
	assign done      = done_q;
	assign refused   = ref_q;
endmodule
`default_nettype wire

// ===== logic/flash_device_end.sv
// Flash side instruction decoder: takes the first byte of each frame
// on the serial clock and reports its class in the system clock domain.
// Assumes the host makes the serial clock and keeps it still while
// chip select is high; clk is the 50 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_device_end import flash_cmd_pkg::*; #(
	parameter int PE_W = `PE_CNT_W
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	flash_link_if.dev_mp         link,
	input  wire logic            cont_mode,
	output logic                 cmd_valid,
	output logic [7:0]           cmd_code,
	output var op_t              cmd_op,
	output var addr_mode_t       cmd_addr,
	output logic [2:0]           cmd_lanes,
	output logic                 cmd_ddr,
	output logic [7:0]           cmd_fmax,
	output logic                 cmd_known,
	output logic                 mode_exit,
	output logic                 link_active,
	output logic [PE_W-1:0]      pe_count
);

	// ----------------------------------------
	// Serial clock domain
	// ----------------------------------------

	// Frame restart: chip select high clears the bit counter
	wire frame_rst = link.cs_n | ~rst_n;

	logic [3:0] cnt_q;     // Bits taken this frame, stops at eight
	logic [6:0] sh_q;      // First seven bits of the byte
	logic [7:0] byte_q;    // Last completed instruction byte
	logic       cm_q;      // Continuous mode seen with that byte
	logic       tgl_q;     // Flips once per completed byte
	logic       cm_s1_q;   // Continuous mode level, first stage
	logic       cm_s2_q;   // Continuous mode level, second stage

	// Last bit of the byte arrives on this edge
	wire last_bit = (cnt_q == `BYTE_BITS - 4'h1);
	// Counter stops once the byte is in
	wire taking   = (cnt_q != `BYTE_BITS);

	// Bit counter and shifter, restarted by each frame
	always_ff @(posedge link.sck or posedge frame_rst) begin
		if (frame_rst) begin
			cnt_q <= 4'h0;
			sh_q  <= 7'h00;
		end else if (taking) begin
			sh_q  <= {sh_q[5:0], link.si};
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Continuous mode level brought onto the serial clock
	always_ff @(posedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			cm_s1_q <= 1'b0;
			cm_s2_q <= 1'b0;
		end else begin
			cm_s1_q <= cont_mode;
			cm_s2_q <= cm_s1_q;
		end
	end

	// Byte capture; later edges of the frame change nothing
	always_ff @(posedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			byte_q <= 8'h00;
			cm_q   <= 1'b0;
			tgl_q  <= 1'b0;
		end else if (last_bit) begin
			byte_q <= {sh_q, link.si};
			cm_q   <= cm_s2_q;
			tgl_q  <= ~tgl_q;
		end
	end

	// ----------------------------------------
	// Crossing into the system clock
	// ----------------------------------------

	logic tg_s1_q;   // Toggle, first stage
	logic tg_s2_q;   // Toggle, second stage
	logic tg_s3_q;   // Toggle, previous value of second stage
	logic cs_s1_q;   // Chip select, first stage
	logic cs_s2_q;   // Chip select, second stage

	// Toggle and chip select through two flops each
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
		end else begin
			tg_s1_q <= tgl_q;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
			cs_s1_q <= link.cs_n;
			cs_s2_q <= cs_s1_q;
		end
	end

	// One pulse per byte; byte_q and cm_q are stable by then
	wire byte_evt = tg_s2_q ^ tg_s3_q;

	// ----------------------------------------
	// Classification
	// ----------------------------------------

	cmd_info_t info;

	opcode_classifier u_cls (
		.code (byte_q),
		.cont (cm_q),
		.info (info)
	);

	// exit byte, whether or not continuous mode is set
	wire exit_hit = byte_evt && (info.op == continuous_mode_exit);
	wire nv_hit   = byte_evt && info.nv_wr;

	// ----------------------------------------
	// Result registers
	// ----------------------------------------

	logic            valid_q;
	logic [7:0]      code_q;
	cmd_info_t       info_q;
	logic            exit_q;
	logic            act_q;
	logic [PE_W-1:0] pe_q;

	// Report every first byte; unknown ones carry known low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			code_q  <= 8'h00;
			info_q  <= '0;
		end else begin
			valid_q <= byte_evt;
			if (byte_evt) begin
				code_q <= byte_q;
				info_q <= info;
			end
		end
	end

	// Continuous mode exit pulse and link activity level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exit_q <= 1'b0;
			act_q  <= 1'b0;
		end else begin
			exit_q <= exit_hit;
			act_q  <= ~cs_s2_q;
		end
	end

	// Wear count of the nonvolatile register array
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pe_q <= '0;
		else if (nv_hit)
			pe_q <= pe_q + 1'b1;
	end

	// ----------------------------------------
	// Outputs straight from flops
	// ----------------------------------------
	assign cmd_valid   = valid_q;
	assign cmd_code    = code_q;
	assign cmd_op      = info_q.op;
	assign cmd_addr    = info_q.addr;
	assign cmd_lanes   = info_q.lanes;
	assign cmd_ddr     = info_q.ddr;
	assign cmd_fmax    = info_q.fmax;
	assign cmd_known   = info_q.known;
	assign mode_exit   = exit_q;
	assign link_active = act_q;
	assign pe_count    = pe_q;

endmodule
`default_nettype wire

// ===== test/flash_link_chk.sv
// Wire checks on the serial link between host end and decoder.
// Assumes a host divider of one: sck toggles every clk in a frame.
`timescale 1ns/1ns
`default_nettype none
module flash_link_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si
);
	logic [3:0] bits_q;
	logic [4:0] span_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Count sck rises and low cycles of each frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bits_q <= 4'h0;
			span_q <= 5'h00;
		end else if (cs_n) begin
			bits_q <= 4'h0;
			span_q <= 5'h00;
		end else begin
			bits_q <= bits_q + {3'h0, $rose(sck)};
			span_q <= span_q + 5'h01;
		end
	end

	// ----------------------------------------
	// Frame shape
	// ----------------------------------------
	// idle clock low
	a_sck_idle_low: assert property (cs_n |-> !sck) else $error("sck high outside frame");
	a_first_rise: assert property ($fell(cs_n) |=> $rose(sck)) else $error("late first sck rise");
	a_high_phase: assert property ($rose(sck) |=> $fell(sck)) else $error("sck high too long");
	a_rise_spacing: assert property ($rose(sck) && bits_q < 4'h7 |-> ##2 $rose(sck)) else $error("rise gap");
	a_eight_bits: assert property ($rose(cs_n) |-> bits_q == 4'h8) else $error("frame not eight bits");
	a_frame_span: assert property ($rose(cs_n) |-> span_q == 5'h11) else $error("frame length wrong");
	a_trail_fall: assert property ($rose(cs_n) |-> $past(sck, 2) && !$past(sck)) else $error("bad frame end");
	a_si_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(si) |-> $fell(sck))
		else $error("si changed off sck fall");

	c_frame_start: cover property ($fell(cs_n));
	c_frame_end: cover property ($rose(cs_n) && bits_q == 4'h8);
	c_data_one: cover property (!cs_n && si);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Bench: host end and flash decoder joined over the serial link.
// Assumes a host divider of one, a 25 MHz link from a 50 MHz clk.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top import flash_cmd_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	logic        cont_mode = 1'b0;
	logic        ref_seen = 1'b0;
	logic        me_seen;
	logic        busy, done, refused, cmd_valid, cmd_ddr, cmd_known, mode_exit, link_active;
	logic [7:0]  opcode = 8'h00;
	logic [7:0]  cmd_code, cmd_fmax;
	logic [2:0]  cmd_lanes;
	logic [31:0] pe_count;
	logic [31:0] pe_exp = 32'h0;
	op_t         cmd_op;
	addr_mode_t  cmd_addr;
	int          miscompares = 0;
	int          checked = 0;
	int          dones = 0;

	flash_link_if i_flash_link_if ();
	flash_host_end #(.SCK_DIV(8'h01)) i_flash_host_end (.clk, .rst_n, .link(i_flash_link_if), .start, .opcode,
		.busy, .done, .refused);
	flash_device_end i_flash_device_end (.clk, .rst_n, .link(i_flash_link_if), .cont_mode, .cmd_valid, .cmd_code,
		.cmd_op, .cmd_addr, .cmd_lanes, .cmd_ddr, .cmd_fmax, .cmd_known, .mode_exit, .link_active, .pe_count);
	flash_link_chk i_flash_link_chk (.clk, .rst_n, .sck(i_flash_link_if.sck), .cs_n(i_flash_link_if.cs_n),
		.si(i_flash_link_if.si));

	// Clock, refusal watch and count of frame end pulses
	always #10 clk = ~clk;
	always @(negedge clk) if (refused === 1'b1) ref_seen = 1'b1;
	always @(negedge clk) if (done === 1'b1) dones++;

	// ----------------------------------------
	// Transfer helpers
	// ----------------------------------------
	task automatic xfer(input logic [7:0] code);
		int n;
		int d0;
		d0 = dones;
		@(posedge clk);
		#2 start = 1'b1;
		opcode = code;
		@(posedge clk);
		#2 start = 1'b0;
		@(posedge clk);
		@(negedge clk);
		`CHK(busy, 1'b1)
		repeat (2) @(negedge clk);
		`CHK(link_active, 1'b1)
		for (n = 0; n < 60 && cmd_valid !== 1'b1; n++)
			@(negedge clk);
		me_seen = mode_exit;
		`CHK(n < 60, 1'b1)
		`CHK(cmd_code, code)
		`CHK(dones, d0 + 1)
		`CHK(busy, 1'b0)
		if (code == 8'h01 || code == 8'h43)
			pe_exp++;
		@(negedge clk);
		`CHK(pe_count, pe_exp)
		`CHK(cmd_valid, 1'b0)
	endtask
	task automatic look(input op_t o, input addr_mode_t a, input logic [2:0] l, input logic d, input logic [7:0] f);
		`CHK(cmd_op, o)
		`CHK(cmd_addr, a)
		`CHK(cmd_lanes, l)
		`CHK(cmd_ddr, d)
		`CHK(cmd_fmax, f)
		`CHK(cmd_known, 1'b1)
	endtask
	task automatic pair(input logic [7:0] c3, c4, input op_t o, input logic [2:0] l, input logic d,
		input logic [7:0] f);
		xfer(c3);
		look(o, addr_3or4, l, d, f);
		xfer(c4);
		look(o, addr_4only, l, d, f);
	endtask
	task automatic one(input logic [7:0] c, input op_t o, input logic k);
		xfer(c);
		`CHK(cmd_op, o)
		`CHK(cmd_known, k)
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reads();
		pair(8'h03, 8'h13, normal_read, 3'h1, 1'b0, 8'h32);
		pair(8'h0b, 8'h0c, quick_read, 3'h1, 1'b0, 8'h85);
		pair(8'h0d, 8'h0e, double_rate_quick_read, 3'h1, 1'b1, 8'h50);
		pair(8'h3b, 8'h3c, two_lane_out_read, 3'h2, 1'b0, 8'h68);
		pair(8'h6b, 8'h6c, four_lane_out_read, 3'h4, 1'b0, 8'h68);
		pair(8'hbb, 8'hbc, two_lane_io_read, 3'h2, 1'b0, 8'h68);
		pair(8'hbd, 8'hbe, double_rate_two_lane_read, 3'h2, 1'b1, 8'h50);
		pair(8'heb, 8'hec, four_lane_io_read, 3'h4, 1'b0, 8'h68);
		pair(8'hed, 8'hee, double_rate_four_lane_read, 3'h4, 1'b1, 8'h50);
	endtask
	task automatic t_writes();
		pair(8'h02, 8'h12, page_prog, 3'h1, 1'b0, 8'h85);
		pair(8'h38, 8'h34, four_lane_page_prog, 3'h4, 1'b0, 8'h50);
		one(8'h32, four_lane_page_prog, 1'b1);
		pair(8'hd8, 8'hdc, sector_wipe, 3'h1, 1'b0, 8'h85);
		one(8'h60, whole_array_wipe, 1'b1);
		one(8'hc7, whole_array_wipe, 1'b1);
		one(8'h01, status_config_write, 1'b1);
		one(8'h06, write_latch_set, 1'b1);
		one(8'h04, write_latch_clear, 1'b1);
		one(8'h30, status_flag_clear, 1'b1);
	endtask
	task automatic t_regs();
		one(8'h16, bank_reg_fetch, 1'b1);
		one(8'h17, bank_reg_store, 1'b1);
		one(8'hb9, bank_reg_legacy_access, 1'b1);
		one(8'h41, learning_pattern_fetch, 1'b1);
		one(8'h43, learning_pattern_nv_store, 1'b1);
		one(8'h4a, learning_pattern_volatile_store, 1'b1);
		one(8'h5a, discoverable_param_read, 1'b1);
		`CHK(cmd_fmax, 8'h85)
		one(8'h9f, identity_read, 1'b1);
		one(8'h90, maker_signature_read, 1'b1);
	endtask
	task automatic t_reserved();
		one(8'he5, op_reserved, 1'b0);
		one(8'he6, op_reserved, 1'b0);
		one(8'ha3, multi_lane_perf_mode, 1'b0);
		one(8'h05, op_unknown, 1'b0);
		one(8'hc0, op_unknown, 1'b0);
		one(8'h03, normal_read, 1'b1);
		one(8'hff, continuous_mode_exit, 1'b1);
		`CHK(me_seen, 1'b1)
	endtask
	task automatic t_cont();
		@(posedge clk);
		#2 cont_mode = 1'b1;
		one(8'hff, continuous_mode_exit, 1'b1);
		`CHK(me_seen, 1'b1)
		one(8'h03, cont_read_addr, 1'b1);
		`CHK(me_seen, 1'b0)
		@(posedge clk);
		#2 cont_mode = 1'b0;
		one(8'h03, normal_read, 1'b1);
	endtask

	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge clk);
		#2 rst_n = 1'b1;
		t_reads();
		t_writes();
		t_regs();
		t_reserved();
		t_cont();
		repeat (2) @(negedge clk);
		`CHK(link_active, 1'b0)
		`CHK(ref_seen, 1'b0)
		test_done();
	end
	initial begin
		#100000;
		miscompares++;
		test_done();
	end
endmodule
`default_nettype wire
